/* File: verilog/ssp_pkg.sv */
/*
  Constants for the four-mode serial port: register byte addresses, field
  positions, reset values, frame lengths and receiver states.
  Assumes an APB slave with 32-bit data and byte addressing in the low 8 bits.
*/
package ssp_pkg;
  // Register byte addresses on the APB.
  localparam logic [7:0] SSP_CTRL_ADDR = 8'h98;
  localparam logic [7:0] SSP_BUF_ADDR  = 8'h9C;
  localparam logic [7:0] SSP_CFG_ADDR  = 8'hA0;
  // Control register field positions.
  localparam int unsigned SSP_B7      = 7;
  localparam int unsigned SSP_MODE_LO = 6;
  localparam int unsigned SSP_FILT    = 5;
  localparam int unsigned SSP_REN     = 4;
  localparam int unsigned SSP_TX9     = 3;
  localparam int unsigned SSP_RX9     = 2;
  localparam int unsigned SSP_TI      = 1;
  localparam int unsigned SSP_RX_DONE = 0;
  // Configuration register field positions.
  localparam int unsigned SSP_VIEW = 0;
  localparam int unsigned SSP_FAST = 1;
  // Reset values.
  localparam logic [7:0] SSP_CTRL_RST = 8'h00;
  localparam logic [1:0] SSP_CFG_RST  = 2'h0;
  // Sixteen sample ticks make one bit; the middle tick checks the start bit.
  localparam logic [3:0] SSP_TICK_LAST = 4'hF;
  localparam logic [3:0] SSP_TICK_MID  = 4'h7;
  // Frame lengths in bits.
  localparam logic [3:0] SSP_M0_BITS  = 4'h8;
  localparam logic [3:0] SSP_M1_BITS  = 4'hA;
  localparam logic [3:0] SSP_M23_BITS = 4'hB;
  // Index of the last data bit shifted in before the stop bit.
  localparam logic [3:0] SSP_M0_LAST  = 4'h7;
  localparam logic [3:0] SSP_M1_LAST  = 4'h7;
  localparam logic [3:0] SSP_M23_LAST = 4'h8;
  // Mode encodings.
  localparam logic [1:0] SSP_MODE0 = 2'h0;
  localparam logic [1:0] SSP_MODE1 = 2'h1;
  localparam logic [1:0] SSP_MODE2 = 2'h2;
  // Receiver states, Gray coded along idle, start, data, stop.
  typedef enum logic [1:0] {
    SSP_RX_IDLE  = 2'h0,
    SSP_RX_START = 2'h1,
    SSP_RX_DATA  = 2'h3,
    SSP_RX_STOP  = 2'h2
  } ssp_rx_st_t;
endpackage : ssp_pkg

/* File: verilog/ssp_serial_port.sv */
/*
  Four-mode serial port with an APB register slave: shift-register mode 0,
  8-bit UART mode 1 and 9-bit UART modes 2 and 3 with address filtering.
  Assumes timer1_overflow_i is a one-cycle pulse from logic on core_clk_i
  and that the receive line arrives asynchronously from a pin.
*/
`timescale 1ns/10ps
// Summary of operation
// - In modes 1 to 3 transmit and receive run together; a new byte overwrites an unread one.
// - Buffer writes load transmit; buffer reads return the separate receive holding byte.
// - Mode 0 shifts eight bits LSB first on the data pin, clocking at half rate.
// - Mode 1 frame is start low, eight data bits LSB first, stop high.
// - Mode 1 reception stores the stop bit into the received ninth bit.
// - Modes 1 and 3 take bit timing from timer overflow pulses.
// - Modes 2 and 3 add a ninth bit, sent from the transmit ninth bit.
// - Modes 2 and 3 store the received ninth bit and ignore the stop value.
// - Mode 2 runs at one sixteenth or one thirty-second of the clock.
// - A buffer write with pstrb_i bit 0 set starts a transmission in every mode.
// - Mode 0 reception starts when receive-done is clear, receive is enabled and no transmission shifts.
// - UART modes start reception on a start bit, only while receive is enabled.
// - With filtering in modes 2 and 3, only ninth bit one completes reception.
// - Mode 0 ignores the filter enable entirely.
// - Mode 1 with filtering completes reception only on a high stop bit.
// - Control register resets to zero and holds the eight listed fields.
// - Bit 7 shows the framing error when view select is one, else mode high.
// - An invalid stop bit sets the framing error; only software clears it.
// - The two mode bits select modes zero to three.
// - The receive enable bit permits reception when one, blocks it when zero.
module ssp_serial_port (
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic [31:0]      prdata_o,
  input  wire logic        timer1_overflow_i,
  output logic             txd_o,
  input  wire logic        rxd_i,
  output logic             rxd_o,
  output logic             rxd_oe_n_o
);

  // Every flip-flop of the port lives in this one record.
  typedef struct packed {
    logic               mode_h;
    logic               mode_l;
    logic               filt;
    logic               ren;
    logic               tx9;
    logic               rx9;
    logic               ti;
    logic               rx_dn;
    logic               ferr;
    logic               view;
    logic               fast;
    logic [7:0]         rx_hold;
    logic               tx_busy;
    logic [10:0]        tx_sh;
    logic [3:0]         tx_cnt;
    logic [3:0]         tx_tick;
    ssp_pkg::ssp_rx_st_t rx_st;
    logic [8:0]         rx_sh;
    logic [3:0]         rx_cnt;
    logic [3:0]         rx_tick;
    logic [2:0]         sync;
    logic               rxd_f;
    logic               rxd_prev;
    logic               ph;
    logic               txd;
    logic               rxd;
    logic               rxd_oe_n;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
  } ssp_state_t;

  ssp_state_t q;
  ssp_state_t d;
  logic [1:0] mode;
  logic       m0;
  logic       s_tick;
  logic       req;
  logic       acc;
  logic       hit;
  logic       wr_ctrl;
  logic       wr_buf;
  logic       wr_cfg;
  logic       rx_fin;
  logic       rx_fin_m0;
  logic       stop_bit;
  logic       nine;
  logic       accept;
  logic [31:0] rdata;

  // Decode of mode, sample tick and bus phases.
  always_comb begin
    mode = {q.mode_h, q.mode_l};
    m0 = (mode == ssp_pkg::SSP_MODE0);
    // Mode 2 samples every clock or every other one; 16 ticks form a bit.
    if (mode == ssp_pkg::SSP_MODE2) begin
      s_tick = q.fast | q.ph;
    end else begin
      s_tick = timer1_overflow_i;
    end
    req = psel_i & penable_i & ~q.pready;
    acc = psel_i & penable_i & q.pready;
    hit = (paddr_i == ssp_pkg::SSP_CTRL_ADDR) | (paddr_i == ssp_pkg::SSP_BUF_ADDR) |
          (paddr_i == ssp_pkg::SSP_CFG_ADDR);
    wr_ctrl = acc & pwrite_i & pstrb_i[0] & (paddr_i == ssp_pkg::SSP_CTRL_ADDR);
    wr_buf = acc & pwrite_i & pstrb_i[0] & (paddr_i == ssp_pkg::SSP_BUF_ADDR);
    wr_cfg = acc & pwrite_i & pstrb_i[0] & (paddr_i == ssp_pkg::SSP_CFG_ADDR);
    case (paddr_i)
      ssp_pkg::SSP_CTRL_ADDR: rdata = {24'h000000, (q.view ? q.ferr : q.mode_h), q.mode_l,
                                       q.filt, q.ren, q.tx9, q.rx9, q.ti, q.rx_dn};
      ssp_pkg::SSP_BUF_ADDR:  rdata = {24'h000000, q.rx_hold};
      ssp_pkg::SSP_CFG_ADDR:  rdata = {30'h0, q.fast, q.view};
      default:                rdata = 32'h00000000;
    endcase
    // UART completion at the stop sample; mode 0 at its eighth clock.
    rx_fin = (q.rx_st == ssp_pkg::SSP_RX_STOP) & s_tick & (q.rx_tick == ssp_pkg::SSP_TICK_LAST);
    rx_fin_m0 = m0 & (q.rx_st == ssp_pkg::SSP_RX_DATA) & ~q.ph &
                (q.rx_cnt == ssp_pkg::SSP_M0_LAST);
    stop_bit = q.rxd_f;
    nine = (mode == ssp_pkg::SSP_MODE1) ? stop_bit : q.rx_sh[8];
    accept = ~q.filt | nine;
  end

  // Next-state logic; control and configuration writes come first so hardware sets win.
  always_comb begin
    d = q;
    // Three-stage line synchroniser; a level counts once stages two and three agree.
    d.sync = {q.sync[1:0], rxd_i};
    if (q.sync[1] == q.sync[2]) begin
      d.rxd_f = q.sync[2];
    end
    d.rxd_prev = q.rxd_f;
    d.ph = ~q.ph;
    // One wait state: data and error are ready in the second access cycle.
    d.pready = req;
    d.pslverr = req & ~hit;
    if (req) begin
      d.prdata = rdata;
    end
    if (wr_ctrl) begin
      if (q.view) begin
        d.ferr = pwdata_i[ssp_pkg::SSP_B7];
      end else begin
        d.mode_h = pwdata_i[ssp_pkg::SSP_B7];
      end
      d.mode_l = pwdata_i[ssp_pkg::SSP_MODE_LO];
      d.filt = pwdata_i[ssp_pkg::SSP_FILT];
      d.ren = pwdata_i[ssp_pkg::SSP_REN];
      d.tx9 = pwdata_i[ssp_pkg::SSP_TX9];
      d.rx9 = pwdata_i[ssp_pkg::SSP_RX9];
      d.ti = pwdata_i[ssp_pkg::SSP_TI];
      d.rx_dn = pwdata_i[ssp_pkg::SSP_RX_DONE];
    end
    if (wr_cfg) begin
      d.view = pwdata_i[ssp_pkg::SSP_VIEW];
      d.fast = pwdata_i[ssp_pkg::SSP_FAST];
    end
    // Transmitter; it shifts on its own counters so reception runs alongside.
    if (q.tx_busy) begin
      if (m0) begin
        if (~q.txd) begin // Shift as the driven clock rises, whatever the phase of ph.
          d.tx_sh = {1'b1, q.tx_sh[10:1]};
          d.tx_cnt = q.tx_cnt - 4'h1;
          if (q.tx_cnt == 4'h1) begin
            d.tx_busy = 1'b0;
            d.ti = 1'b1;
          end
        end
      end else if (s_tick) begin
        d.tx_tick = q.tx_tick + 4'h1;
        if (q.tx_tick == ssp_pkg::SSP_TICK_LAST) begin
          d.tx_sh = {1'b1, q.tx_sh[10:1]};
          d.tx_cnt = q.tx_cnt - 4'h1;
          if (q.tx_cnt == 4'h1) begin
            d.tx_busy = 1'b0;
            d.ti = 1'b1;
          end
        end
      end
    end
    // A buffer write restarts the transmitter even mid-frame.
    if (wr_buf) begin
      d.tx_busy = 1'b1;
      d.tx_tick = 4'h0;
      if (m0) begin
        d.tx_sh = {3'b111, pwdata_i[7:0]};
        d.tx_cnt = ssp_pkg::SSP_M0_BITS;
      end else if (mode == ssp_pkg::SSP_MODE1) begin
        d.tx_sh = {2'b11, pwdata_i[7:0], 1'b0};
        d.tx_cnt = ssp_pkg::SSP_M1_BITS;
      end else begin
        d.tx_sh = {1'b1, q.tx9, pwdata_i[7:0], 1'b0};
        d.tx_cnt = ssp_pkg::SSP_M23_BITS;
      end
    end
    // Receiver state machine.
    case (q.rx_st)
      ssp_pkg::SSP_RX_IDLE: begin
        if (m0) begin
          // Half duplex: mode 0 reception waits while a transmission shifts.
          if (q.ren & ~q.rx_dn & ~q.tx_busy & q.ph) begin
            d.rx_st = ssp_pkg::SSP_RX_DATA;
            d.rx_cnt = 4'h0;
          end
        end else if (q.ren & q.rxd_prev & ~q.rxd_f) begin
          d.rx_st = ssp_pkg::SSP_RX_START;
          d.rx_tick = 4'h0;
        end
      end
      ssp_pkg::SSP_RX_START: begin
        if (s_tick) begin
          d.rx_tick = q.rx_tick + 4'h1;
          if (q.rx_tick == ssp_pkg::SSP_TICK_MID) begin
            // A line high again at mid-bit was a glitch, not a start bit.
            d.rx_st = q.rxd_f ? ssp_pkg::SSP_RX_IDLE : ssp_pkg::SSP_RX_DATA;
            d.rx_tick = 4'h0;
            d.rx_cnt = 4'h0;
          end
        end
      end
      ssp_pkg::SSP_RX_DATA: begin
        if (m0) begin
          if (~q.ph) begin
            d.rx_sh = {q.rxd_f, q.rx_sh[8:1]};
            d.rx_cnt = q.rx_cnt + 4'h1;
            if (rx_fin_m0) begin
              d.rx_st = ssp_pkg::SSP_RX_IDLE;
              d.rx_hold = {q.rxd_f, q.rx_sh[8:2]};
              d.rx_dn = 1'b1;
            end
          end
        end else if (s_tick) begin
          d.rx_tick = q.rx_tick + 4'h1;
          if (q.rx_tick == ssp_pkg::SSP_TICK_LAST) begin
            d.rx_sh = {q.rxd_f, q.rx_sh[8:1]};
            d.rx_cnt = q.rx_cnt + 4'h1;
            if (q.rx_cnt == ((mode == ssp_pkg::SSP_MODE1) ? ssp_pkg::SSP_M1_LAST
                                                           : ssp_pkg::SSP_M23_LAST)) begin
              d.rx_st = ssp_pkg::SSP_RX_STOP;
            end
          end
        end
      end
      ssp_pkg::SSP_RX_STOP: begin
        if (s_tick) begin
          d.rx_tick = q.rx_tick + 4'h1;
        end
        if (rx_fin) begin
          d.rx_st = ssp_pkg::SSP_RX_IDLE;
          if (~stop_bit) begin
            d.ferr = 1'b1;
          end
          if (accept) begin
            d.rx_hold = (mode == ssp_pkg::SSP_MODE1) ? q.rx_sh[8:1] : q.rx_sh[7:0];
            d.rx9 = nine;
            d.rx_dn = 1'b1;
          end
        end
      end
      default: d.rx_st = ssp_pkg::SSP_RX_IDLE;
    endcase
    // Pins: mode 0 drives the shift clock on txd and data on the two-way line.
    if (m0) begin
      d.txd = q.tx_busy ? ~q.txd : ((q.rx_st == ssp_pkg::SSP_RX_DATA) ? q.ph : 1'b1);
    end else begin
      d.txd = q.tx_busy ? q.tx_sh[0] : 1'b1;
    end
    d.rxd = q.tx_sh[0];
    d.rxd_oe_n = ~(m0 & q.tx_busy);
  end

  // State register; the whole record resets to constants.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
      q.sync <= 3'b111;
      q.rxd_f <= 1'b1;
      q.rxd_prev <= 1'b1;
      q.tx_sh <= 11'h7FF;
      q.txd <= 1'b1;
      q.rxd <= 1'b1;
      q.rxd_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign pready_o = q.pready;
  assign pslverr_o = q.pslverr;
  assign prdata_o = q.prdata;
  assign txd_o = q.txd;
  assign rxd_o = q.rxd;
  assign rxd_oe_n_o = q.rxd_oe_n;

  // Checks next to the logic they guard.
  AST_TX_START: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    wr_buf |=> q.tx_busy) else $error("buffer write did not start transmit");
  AST_BUF_READ: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    req && !pwrite_i && paddr_i == ssp_pkg::SSP_BUF_ADDR |=> prdata_o[7:0] == $past(q.rx_hold))
    else $error("buffer read did not return receive holding byte");
  AST_M0_CLOCK: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (m0 && q.tx_busy) ##1 (m0 && q.tx_busy) |=> txd_o != $past(txd_o))
    else $error("mode 0 shift clock not at half rate");
  AST_START_LOW: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    !m0 && $rose(q.tx_busy) && !$past(wr_ctrl) |=> !txd_o)
    else $error("start bit not low");
  AST_M1_NINTH: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    rx_fin && accept && mode == ssp_pkg::SSP_MODE1 |=> q.rx9 == $past(stop_bit))
    else $error("mode 1 stop bit not stored");
  AST_MP_FILTER: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    rx_fin && mode[1] && q.filt && !q.rx_sh[8] && !wr_ctrl && !q.rx_dn |=> !q.rx_dn)
    else $error("filtered data byte completed reception");
  AST_M1_FILTER: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    rx_fin && mode == ssp_pkg::SSP_MODE1 && q.filt && !stop_bit && !wr_ctrl && !q.rx_dn
    |=> !q.rx_dn) else $error("invalid stop bit completed mode 1 reception");
  AST_FRAME_ERR_SET: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    rx_fin && !stop_bit |=> q.ferr) else $error("framing error not flagged");
  AST_REN_GATE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    q.rx_st == ssp_pkg::SSP_RX_IDLE && !q.ren |=> q.rx_st == ssp_pkg::SSP_RX_IDLE)
    else $error("reception started while disabled");
  AST_M0_RX: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    m0 && q.rx_st == ssp_pkg::SSP_RX_IDLE && q.ren && !q.rx_dn && !q.tx_busy && q.ph
    |=> q.rx_st == ssp_pkg::SSP_RX_DATA) else $error("mode 0 reception did not start");
  AST_TI_HOLD: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    q.ti && !wr_ctrl |=> q.ti) else $error("transmit done cleared without software");

endmodule : ssp_serial_port

/* File: testbench/ssp_remote.sv */
/*
  Behavioural model of the remote serial node on the far side of the port.
  Assumes it shares core_clk_i with the port and that the bench feeds it the
  resolved level of the two-way data line.
*/
`timescale 1ns/10ps
module ssp_remote (
  input  wire logic clk_i,
  input  wire logic txd_i,
  input  wire logic dq_i,
  output logic      line_o
);
  // The line idles high between frames, as a stop bit would leave it.
  initial line_o = 1'b1;

  // Set when a wait for the port runs out of time; the bench ends the run on it.
  logic hung = 1'b0;

  // Sends n bits LSB first, start bit in bit 0; per is clocks per bit.
  task automatic send(input logic [10:0] b, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      line_o <= b[i];
      repeat (per) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask : send

  // Waits for a start bit, then samples each bit in its middle.
  task automatic recv(input int n, input int per, output logic [10:0] b);
    int t;
    t = 0;
    b = '0;
    while (txd_i !== 1'b0 && t < 4000) begin
      @(posedge clk_i);
      t++;
    end
    if (t >= 4000) begin
      hung = 1'b1;
    end
    repeat (per / 2) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      b[i] = txd_i;
      repeat (per) @(posedge clk_i);
    end
  endtask : recv

  // Shift-register capture: data is taken as the shift clock rises.
  task automatic m0cap(output logic [7:0] b);
    int   t;
    int   i;
    logic p;
    t = 0;
    i = 0;
    b = '0;
    p = txd_i;
    while (i < 8 && t < 2000) begin
      @(posedge clk_i);
      t++;
      if (txd_i === 1'b1 && p === 1'b0) begin
        b[i] = dq_i;
        i++;
      end
      p = txd_i;
    end
    if (i < 8) begin
      hung = 1'b1;
    end
  endtask : m0cap
endmodule : ssp_remote

/* File: testbench/test_ssp_serial_port.sv */
/*
  Self-checking bench for the serial port: APB register access and frames
  exchanged with a remote node model in all four modes.
  Assumes the register map and one-wait-state answer of the design.
*/
`timescale 1ns/10ps
module test_ssp_serial_port;
  localparam logic [7:0] CA = ssp_pkg::SSP_CTRL_ADDR;
  localparam logic [7:0] BA = ssp_pkg::SSP_BUF_ADDR;
  localparam logic [7:0] GA = ssp_pkg::SSP_CFG_ADDR;
  logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, tmr = 0;
  logic [7:0]  pa  = '0;
  logic [31:0] pwd = '0, rd;
  logic [3:0]  pst = 4'hF;
  logic        err;
  logic [10:0] fr;
  logic [7:0]  b8;
  wire         pready, pslverr, txd, rxo, oen, rem_line;
  wire  [31:0] prd;
  int          fails = 0, cmp_count = 0;
  // The two-way data line: the port wins while its enable is low.
  wire         rx_line = oen ? rem_line : rxo;

  // Clock, and a timer overflow pulse every second clock.
  always #10 clk = ~clk;
  always @(posedge clk) tmr <= ~tmr;

  ssp_serial_port dut (.core_clk_i(clk), .arst_n_i(rst_n), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .pstrb_i(pst), .pready_o(pready),
    .pslverr_o(pslverr), .prdata_o(prd), .timer1_overflow_i(tmr), .txd_o(txd),
    .rxd_i(rx_line), .rxd_o(rxo), .rxd_oe_n_o(oen));
  ssp_remote rem (.clk_i(clk), .txd_i(txd), .dq_i(rx_line), .line_o(rem_line));

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr  <= w;
    pa   <= a;
    pwd  <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    rd = prd;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    if (t >= 50) begin
      fails++;
      conclude();
    end
  endtask : apb

  // A partner wait that ran out counts as a mismatch and ends the run.
  task automatic wait_ok();
    if (rem.hung) begin
      fails++;
      conclude();
    end
  endtask : wait_ok

  // Sends a frame, lets the receiver settle, and checks the control byte.
  task automatic rxc(input logic [10:0] f, input int n, input int per, input logic [31:0] c);
    rem.send(f, n, per);
    repeat (8) @(posedge clk);
    apb(1'b0, CA, '0);
    chk("ctrl", c, rd);
  endtask : rxc

  // Main sequence; each group ends with one progress line.
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, CA, 0); chk("ctrl reset", 32'h00, rd);
    apb(0, GA, 0); chk("cfg reset", 32'h00, rd);
    apb(0, 8'h10, 0); chk("unmapped err", 1, err);
    $display("test reset done");
    apb(1, CA, 32'h50);
    fork
      rem.send({1'b1, 8'hA5, 1'b0}, 10, 32);
      begin apb(1, BA, 32'h3C); rem.recv(10, 32, fr); end
    join
    wait_ok();
    chk("m1 tx frame", {1'b1, 8'h3C, 1'b0}, fr[9:0]);
    repeat (8) @(posedge clk);
    apb(0, CA, 0); chk("m1 ctrl", 32'h57, rd);
    apb(0, BA, 0); chk("m1 buf", 32'hA5, rd);
    apb(1, CA, 32'h50);
    rem.send({1'b1, 8'h11, 1'b0}, 10, 32);
    rxc({1'b1, 8'h22, 1'b0}, 10, 32, 32'h55);
    apb(0, BA, 0); chk("overrun buf", 32'h22, rd);
    apb(1, CA, 32'h70);
    rxc({1'b0, 8'h33, 1'b0}, 10, 32, 32'h70);
    apb(1, GA, 32'h1);
    apb(0, CA, 0); chk("fe view", 32'hF0, rd);
    apb(1, CA, 32'h50);
    apb(0, CA, 0); chk("fe cleared", 32'h50, rd);
    apb(1, GA, 32'h0);
    apb(1, CA, 32'h40);
    rxc({1'b1, 8'h44, 1'b0}, 10, 32, 32'h40);
    $display("test mode1 done");
    apb(1, GA, 32'h2);
    apb(1, CA, 32'h98);
    fork
      rem.send({1'b0, 1'b1, 8'hC3, 1'b0}, 11, 16);
      begin apb(1, BA, 32'h5A); rem.recv(11, 16, fr); end
    join
    wait_ok();
    chk("m2 tx frame", {1'b1, 1'b1, 8'h5A, 1'b0}, fr);
    repeat (8) @(posedge clk);
    apb(0, CA, 0); chk("m2 ctrl", 32'h9F, rd);
    apb(0, BA, 0); chk("m2 buf", 32'hC3, rd);
    apb(1, GA, 32'h0);
    apb(1, CA, 32'h80);
    fork
      apb(1, BA, 32'h0F);
      rem.recv(11, 32, fr);
    join
    wait_ok();
    chk("m2 slow frame", {1'b1, 1'b0, 8'h0F, 1'b0}, fr);
    $display("test mode2 done");
    apb(1, CA, 32'hF0);
    rxc({1'b1, 1'b0, 8'h66, 1'b0}, 11, 32, 32'hF0);
    rxc({1'b1, 1'b1, 8'h77, 1'b0}, 11, 32, 32'hF5);
    apb(0, BA, 0); chk("m3 buf", 32'h77, rd);
    $display("test mode3 done");
    apb(1, CA, 32'h00);
    fork
      apb(1, BA, 32'h96);
      rem.m0cap(b8);
    join
    wait_ok();
    chk("m0 tx byte", 32'h96, b8);
    repeat (8) @(posedge clk);
    chk("m0 line released", 1, oen);
    apb(0, CA, 0); chk("m0 tx done", 32'h02, rd);
    apb(1, CA, 32'h30);
    repeat (60) @(posedge clk);
    apb(0, CA, 0); chk("m0 rx ctrl", 32'h31, rd);
    apb(0, BA, 0); chk("m0 rx buf", 32'hFF, rd);
    $display("test mode0 done");
    conclude();
  end
endmodule : test_ssp_serial_port
